// *** core/nwds_top.sv ***
// NMI pin routing, standby wakeup sequencing and low-power entry gating.
`timescale 1ns/1ps
// Functional notes
// - A standby wakeup by the NMI pin powers the core domain and then releases core reset.
// - An NMI pending from a standby wakeup when core reset is released before the vector base is set makes the core fetch at 0x10 and stall in machine check.
// - With destination 11 the NMI pin gives no core interrupt but still wakes the system.
// - Wakeup inputs 2 to 14 and 19 exist on every variant, though a package may leave some unbonded.
// - Low-power entry is refused while any CAN controller is enabled and not module-disabled.
// - Destination 00 routes the NMI pin event to the core as a non-maskable interrupt.
module nwds_top
    import nwds_pkg::*;
#(
    parameter int NUM_WK = 32,
    parameter int NUM_CAN = 3,
    parameter logic [31:0] ID_CODE = 32'h0000_0A5A // Arbitrary identification value.
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // Register port.
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Pins and wakeup sources.
    input wire logic nmi_pin_i,
    input wire logic [NUM_WK-1:0] wakeup_input_i,
    // Low-power mode controller.
    input wire logic lp_req_i,
    input wire logic lp_standby_i,
    output logic lp_grant_o,
    output logic lp_refused_o,
    output logic [NUM_WK-1:0] wake_o,
    // CAN controller state.
    input wire logic [NUM_CAN-1:0] can_run_enabled_i,
    input wire logic [NUM_CAN-1:0] can_module_disable_bit_i,
    // Core side.
    input wire logic vector_prefix_valid_i,
    output logic core_pwr_on_o,
    output logic core_rst_b_o,
    output nwds_core_irq_s core_irq_o,
    output logic core_mchk_stall_o,
    output logic [31:0] core_fetch_addr_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [1:0] dest;
        logic nmi_wake_en;
        logic [31:0] wk_en;
        nwds_pwr_e pwr;
        logic [3:0] pwr_cnt;
        logic nmi_pin_d;
        logic nmi_pend;
        logic [NWDS_IRQ_W-1:0] irq_st;
        logic [NWDS_IRQ_W-1:0] irq_en;
        logic [31:0] rdata;
        logic lp_grant;
        logic lp_refused;
        logic [NUM_WK-1:0] wake;
        logic nmi_out;
        logic crit_out;
        logic mchk_out;
        logic stall;
        logic [31:0] fetch;
    } nwds_state_s;

    nwds_state_s st_reg;
    nwds_state_s st_next;
    nwds_bus_s bus;
    logic [31:0] wk_present;
    logic can_active;
    logic nmi_edge;
    logic wk_any;

    assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    // Only the family-wide inputs are implemented; the rest read and wake as zero.
    always_comb begin
        wk_present = NWDS_WK_COMMON_MASK;
    end

    assign can_active = |(can_run_enabled_i & ~can_module_disable_bit_i);
    assign nmi_edge = nmi_pin_i & ~st_reg.nmi_pin_d;

    always_comb begin
        logic [31:0] wk_vec;
        wk_vec = '0;
        wk_vec[NUM_WK-1:0] = wakeup_input_i;
        wk_any = |(wk_vec & st_reg.wk_en & wk_present);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [NWDS_IRQ_W-1:0] ev;
        logic [31:0] wk_vec;
        logic [31:0] wake_vec;
        ev = '0;
        wk_vec = '0;
        wk_vec[NUM_WK-1:0] = wakeup_input_i;
        wake_vec = '0;
        st_next = st_reg;
        st_next.nmi_pin_d = nmi_pin_i;
        st_next.lp_grant = 1'b0;
        st_next.lp_refused = 1'b0;
        st_next.nmi_out = 1'b0;
        st_next.crit_out = 1'b0;
        st_next.mchk_out = 1'b0;

        if (bus.wr) begin
            unique case (bus.addr)
                NWDS_OFF_NMI_CFG: begin
                    st_next.dest = bus.wdata[NWDS_POS_DEST +: 2];
                    st_next.nmi_wake_en = bus.wdata[NWDS_POS_WAKE_EN];
                end
                NWDS_OFF_WK_EN: st_next.wk_en = bus.wdata & wk_present;
                NWDS_OFF_IRQ_EN: st_next.irq_en = bus.wdata[NWDS_IRQ_W-1:0];
                NWDS_OFF_IRQ_CLR: st_next.irq_st = st_reg.irq_st & ~bus.wdata[NWDS_IRQ_W-1:0];
                default: ;
            endcase
        end

        // A request while a CAN controller runs is refused and reported.
        if (lp_req_i && st_reg.pwr == NWDS_ST_RUN) begin
            if (can_active) begin
                st_next.lp_refused = 1'b1;
                ev[NWDS_IRQ_LP_REFUSED] = 1'b1;
            end else begin
                st_next.lp_grant = 1'b1;
                if (lp_standby_i) begin
                    st_next.pwr = NWDS_ST_STANDBY;
                end
            end
        end

        unique case (st_reg.pwr)
            NWDS_ST_RUN: begin
                // Pin routing while the core runs.
                if (nmi_edge) begin
                    unique case (st_reg.dest)
                        NWDS_DEST_NMI: st_next.nmi_out = 1'b1;
                        NWDS_DEST_CRIT: st_next.crit_out = 1'b1;
                        NWDS_DEST_MCHK: st_next.mchk_out = 1'b1;
                        NWDS_DEST_WAKE_ONLY: ;
                    endcase
                end
            end
            NWDS_ST_STANDBY: begin
                if ((nmi_edge && st_reg.nmi_wake_en) || wk_any) begin
                    st_next.pwr = NWDS_ST_POWER_UP;
                    st_next.pwr_cnt = NWDS_PWR_UP_CYC;
                    if (nmi_edge && st_reg.nmi_wake_en) begin
                        ev[NWDS_IRQ_NMI_WAKE] = 1'b1;
                        // The pending NMI reaches the core only when not wake-only.
                        st_next.nmi_pend = (st_reg.dest != NWDS_DEST_WAKE_ONLY);
                    end
                    if (wk_any) begin
                        ev[NWDS_IRQ_WK] = 1'b1;
                        wake_vec = wk_vec & st_reg.wk_en & wk_present;
                    end
                end
            end
            NWDS_ST_POWER_UP: begin
                st_next.pwr_cnt = st_reg.pwr_cnt - 4'h1;
                if (st_reg.pwr_cnt == 4'h1) begin
                    st_next.pwr = NWDS_ST_RELEASE;
                end
            end
            NWDS_ST_RELEASE: begin
                // Core reset is released; a pending NMI is seen on its first edge.
                st_next.pwr = NWDS_ST_RUN;
                st_next.nmi_pend = 1'b0;
                if (st_reg.nmi_pend) begin
                    unique case (st_reg.dest)
                        NWDS_DEST_NMI: st_next.nmi_out = 1'b1;
                        NWDS_DEST_CRIT: st_next.crit_out = 1'b1;
                        NWDS_DEST_MCHK: st_next.mchk_out = 1'b1;
                        NWDS_DEST_WAKE_ONLY: ;
                    endcase
                    // Without a vector base the fetch lands at 0x10 with flash off.
                    if (!vector_prefix_valid_i) begin
                        st_next.fetch = NWDS_NMI_RAW_FETCH;
                        st_next.stall = 1'b1;
                        ev[NWDS_IRQ_MCHK_STALL] = 1'b1;
                    end
                end
            end
        endcase

        if (st_reg.pwr == NWDS_ST_STANDBY) begin
            st_next.wake = wake_vec[NUM_WK-1:0];
        end else begin
            st_next.wake = '0;
        end
        // A stall lasts until the core is reset again by a new standby.
        if (st_next.pwr == NWDS_ST_STANDBY) begin
            st_next.stall = 1'b0;
        end

        // Set wins over a clear in the same cycle.
        st_next.irq_st = st_next.irq_st | ev;

        st_next.rdata = '0;
        if (bus.rd) begin
            unique case (bus.addr)
                NWDS_OFF_NMI_CFG: begin
                    st_next.rdata[NWDS_POS_DEST +: 2] = st_reg.dest;
                    st_next.rdata[NWDS_POS_WAKE_EN] = st_reg.nmi_wake_en;
                end
                NWDS_OFF_WK_EN: st_next.rdata = st_reg.wk_en;
                NWDS_OFF_CAN_CFG: st_next.rdata = {31'h0, can_active};
                NWDS_OFF_STATUS: st_next.rdata = {27'h0, st_reg.stall, st_reg.nmi_pend, st_reg.pwr, can_active};
                NWDS_OFF_IRQ_ST: st_next.rdata[NWDS_IRQ_W-1:0] = st_reg.irq_st;
                NWDS_OFF_IRQ_EN: st_next.rdata[NWDS_IRQ_W-1:0] = st_reg.irq_en;
                NWDS_OFF_ID: st_next.rdata = ID_CODE;
                default: st_next.rdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '{dest: NWDS_RST_DEST, wk_en: NWDS_RST_WK_EN, pwr: NWDS_ST_RUN, default: '0};
        end else if (clk_en_i) begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o = st_reg.rdata;
    assign lp_grant_o = st_reg.lp_grant;
    assign lp_refused_o = st_reg.lp_refused;
    assign wake_o = st_reg.wake;
    assign core_pwr_on_o = (st_reg.pwr != NWDS_ST_STANDBY);
    assign core_rst_b_o = (st_reg.pwr == NWDS_ST_RUN) || (st_reg.pwr == NWDS_ST_RELEASE);
    assign core_irq_o = '{nmi: {1'b0, st_reg.nmi_out}, crit: {1'b0, st_reg.crit_out},
                          mchk: {1'b0, st_reg.mchk_out}};
    assign core_mchk_stall_o = st_reg.stall;
    assign core_fetch_addr_o = st_reg.fetch;
    assign irq_o = |(st_reg.irq_st & st_reg.irq_en);

endmodule

// *** core/nwds_pkg.sv ***
// Package for the NMI and wakeup destination-select block.
package nwds_pkg;
    // Register word offsets, used as byte addresses.
    localparam logic [7:0] NWDS_OFF_NMI_CFG = 8'h00;
    localparam logic [7:0] NWDS_OFF_WK_EN = 8'h04;
    localparam logic [7:0] NWDS_OFF_CAN_CFG = 8'h08;
    localparam logic [7:0] NWDS_OFF_STATUS = 8'h0C;
    localparam logic [7:0] NWDS_OFF_IRQ_ST = 8'h10;
    localparam logic [7:0] NWDS_OFF_IRQ_EN = 8'h14;
    localparam logic [7:0] NWDS_OFF_IRQ_CLR = 8'h18;
    localparam logic [7:0] NWDS_OFF_ID = 8'h1C;
    // Field positions of the NMI configuration register.
    localparam int NWDS_POS_DEST = 0;
    localparam int NWDS_POS_WAKE_EN = 2;
    // Destination encodings.
    localparam logic [1:0] NWDS_DEST_NMI = 2'h0;
    localparam logic [1:0] NWDS_DEST_CRIT = 2'h1;
    localparam logic [1:0] NWDS_DEST_MCHK = 2'h2;
    localparam logic [1:0] NWDS_DEST_WAKE_ONLY = 2'h3;
    // Reset values.
    localparam logic [1:0] NWDS_RST_DEST = 2'h3;
    localparam logic [31:0] NWDS_RST_WK_EN = 32'h0000_0000;
    // Wakeup inputs present on every variant: 2 to 14 and 19.
    localparam logic [31:0] NWDS_WK_COMMON_MASK = 32'h0008_7FFC;
    // Fetch address used by an NMI before the vector base is set up.
    localparam logic [31:0] NWDS_NMI_RAW_FETCH = 32'h0000_0010;
    // Interrupt status bit positions.
    localparam int NWDS_IRQ_NMI_WAKE = 0;
    localparam int NWDS_IRQ_LP_REFUSED = 1;
    localparam int NWDS_IRQ_MCHK_STALL = 2;
    localparam int NWDS_IRQ_WK = 3;
    localparam int NWDS_IRQ_W = 4;
    // Core power-up sequence length in cycles.
    localparam logic [3:0] NWDS_PWR_UP_CYC = 4'h4;

    typedef enum logic [1:0] {
        NWDS_ST_RUN = 2'b00,
        NWDS_ST_STANDBY = 2'b01,
        NWDS_ST_POWER_UP = 2'b10,
        NWDS_ST_RELEASE = 2'b11
    } nwds_pwr_e;

    typedef struct packed {
        logic [1:0] nmi;
        logic [1:0] crit;
        logic [1:0] mchk;
    } nwds_core_irq_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } nwds_bus_s;
endpackage

// *** testbench/nwds_props.sv ***
// Checker for NMI routing, standby wake order and low-power gating.
`timescale 1ns/1ps
module nwds_props
    import nwds_pkg::*;
#(
    parameter int NUM_CAN = 3
) (
    // Clock, reset and register writes.
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    // Pin, low-power and CAN state.
    input wire logic nmi_pin_i,
    input wire logic lp_grant_o,
    input wire logic lp_refused_o,
    input wire logic [NUM_CAN-1:0] can_run_enabled_i,
    input wire logic [NUM_CAN-1:0] can_module_disable_bit_i,
    // Core side.
    input wire logic vector_prefix_valid_i,
    input wire logic core_pwr_on_o,
    input wire logic core_rst_b_o,
    input wire nwds_core_irq_s core_irq_o,
    input wire logic core_mchk_stall_o,
    input wire logic [31:0] core_fetch_addr_o
);
    logic [1:0] dest_q;
    logic can_on;
    assign can_on = |(can_run_enabled_i & ~can_module_disable_bit_i);
    // The destination field is internal, so it is rebuilt here from the writes that set it.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dest_q <= NWDS_RST_DEST;
        end else if (clk_en_i && reg_wr_i && reg_addr_i == NWDS_OFF_NMI_CFG) begin
            dest_q <= reg_wdata_i[1:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    grant_gate_a: assert property (lp_grant_o |-> !$past(can_on)) else $error("grant with CAN on");
    refuse_pulse_a: assert property (lp_refused_o |-> $past(can_on) && !lp_grant_o ##1 !lp_refused_o)
        else $error("bad refusal");
    quiet_dest_a: assert property ($past(dest_q) == 2'h3 |-> core_irq_o == 6'h00) else $error("irq in wake only");
    // Reset free now and a cycle ago means the run state; in the release cycle only a pending event is routed.
    nmi_route_a: assert property ($rose(nmi_pin_i) && dest_q == 2'h0 && core_rst_b_o && $past(core_rst_b_o)
        && vector_prefix_valid_i |=> core_irq_o.nmi == 2'h1) else $error("NMI not routed");
    power_order_a: assert property (!core_pwr_on_o |-> !core_rst_b_o) else $error("reset free unpowered");
    release_delay_a: assert property ($rose(core_rst_b_o) |-> $past(core_pwr_on_o, 4)) else $error("early release");
    stall_fetch_a: assert property (core_mchk_stall_o |-> core_fetch_addr_o == NWDS_NMI_RAW_FETCH)
        else $error("stall fetch address");
    stall_cause_a: assert property ($rose(core_mchk_stall_o) |-> !$past(vector_prefix_valid_i))
        else $error("stall with vectors set");
    cover property (lp_refused_o);
    cover property ($rose(core_rst_b_o));
    cover property ($rose(core_mchk_stall_o));
endmodule

bind nwds_top nwds_props #(.NUM_CAN(NUM_CAN)) u_props (.*);

// *** testbench/nwds_core_model.sv ***
// Core model: loses its vector base in reset and sets it up again after a boot delay.
`timescale 1ns/1ps
module nwds_core_model (
    // Clock, reset and boot pacing.
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] boot_cyc_i,
    // Core reset from the block and vector state back.
    input wire logic core_rst_b_i,
    output logic vector_prefix_valid_o
);
    logic [3:0] cnt_reg;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_reg <= 4'h0;
            vector_prefix_valid_o <= 1'h1;
        end else if (!core_rst_b_i) begin
            cnt_reg <= 4'h0;
            vector_prefix_valid_o <= 1'h0;
        end else if (cnt_reg == boot_cyc_i) begin
            vector_prefix_valid_o <= 1'h1;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule

// *** testbench/nwds_top_tb.sv ***
// Self-checking bench for the NMI routing and wakeup block.
`timescale 1ns/1ps
module nwds_top_tb;
    import nwds_pkg::*;
    localparam logic [31:0] ID = 32'h0000_C3A5; // Arbitrary identification value.
    logic clk_i = 1'h0, rst_b_i = 1'h0, clk_en_i = 1'h1, reg_wr_i = 1'h0, reg_rd_i = 1'h0, rd_q = 1'h0;
    logic nmi_pin_i = 1'h0, lp_req_i = 1'h0, lp_standby_i = 1'h0, vector_prefix_valid_i;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, wakeup_input_i = 32'h0, reg_rdata_o, core_fetch_addr_o, r, wake_o;
    logic [2:0] can_run_enabled_i = 3'h0, can_module_disable_bit_i = 3'h0;
    logic [3:0] boot_cyc = 4'h0;
    logic lp_grant_o, lp_refused_o, core_pwr_on_o, core_rst_b_o, core_mchk_stall_o, irq_o;
    nwds_core_irq_s core_irq_o;
    logic [31:0] exp_q[$];
    logic [31:0] exp_w[$];
    int error_cnt = 0, compares = 0, irq_seen = 0;

    nwds_top #(.ID_CODE(ID)) uut (.*);
    nwds_core_model core (.clk_i(clk_i), .rst_b_i(rst_b_i), .boot_cyc_i(boot_cyc),
        .core_rst_b_i(core_rst_b_o), .vector_prefix_valid_o(vector_prefix_valid_i));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i <= wr;
        reg_rd_i <= !wr;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'h0;
        reg_rd_i <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'h0, a, 32'h0);
    endtask
    task automatic irq_is(input logic e);
        @(posedge clk_i);
        #1 chk("irq", irq_o, e);
    endtask
    task automatic lp_try(input logic sb, input logic [2:0] run, input logic [2:0] dis, input logic ref_e);
        @(posedge clk_i);
        lp_standby_i <= sb;
        lp_req_i <= 1'h1;
        can_run_enabled_i <= run;
        can_module_disable_bit_i <= dis;
        @(posedge clk_i);
        lp_req_i <= 1'h0;
        #1 chk("refused", lp_refused_o, ref_e);
        chk("grant", lp_grant_o, !ref_e);
    endtask
    // Sleeps, wakes by the pin or by the given inputs and checks what the core sees once its reset is released.
    task automatic nap(input logic [2:0] cfg, input logic [3:0] boot, input logic st, input logic [31:0] wk);
        int base;
        bus(1'h1, NWDS_OFF_NMI_CFG, {29'h0, cfg});
        boot_cyc <= boot;
        base = irq_seen;
        if (wk != 32'h0) exp_w.push_back(wk & NWDS_WK_COMMON_MASK);
        lp_try(1'h1, 3'h0, 3'h0, 1'h0);
        #1 chk("power", core_pwr_on_o, 1'h0);
        @(posedge clk_i);
        nmi_pin_i <= (wk == 32'h0);
        wakeup_input_i <= wk;
        for (int i = 0; i < 20 && core_rst_b_o !== 1'h1; i++) @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        nmi_pin_i <= 1'h0;
        wakeup_input_i <= 32'h0;
        #1 chk("core reset", core_rst_b_o, 1'h1);
        chk("stall", core_mchk_stall_o, st);
        chk("core irqs", irq_seen - base, 32'(st));
        if (st) chk("fetch", core_fetch_addr_o, NWDS_NMI_RAW_FETCH);
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    // Read data stand only in the cycle after the strobe, so they are taken at that one edge.
    always @(posedge clk_i) begin
        if (rd_q) chk("read data", reg_rdata_o, exp_q.pop_front());
        if (|wake_o) chk("wake", wake_o, exp_w.pop_front());
        if (|core_irq_o) irq_seen++;
        rd_q <= reg_rd_i;
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(72037));
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'h1;
        rd(NWDS_OFF_NMI_CFG, 32'h3);
        rd(NWDS_OFF_ID, ID);
        rd(8'h20, 32'h0);
        r = $urandom();
        bus(1'h1, NWDS_OFF_WK_EN, r);
        rd(NWDS_OFF_WK_EN, r & NWDS_WK_COMMON_MASK);
        for (int d = 0; d < 4; d++) begin
            bus(1'h1, NWDS_OFF_NMI_CFG, 32'(d));
            nmi_pin_i <= 1'h1;
            @(posedge clk_i);
            nmi_pin_i <= 1'h0;
            #1 chk("core irq", 32'(core_irq_o), d == 3 ? 32'h0 : 32'h1 << (4 - 2 * d));
        end
        for (int c = 0; c < 3; c++) lp_try(1'(c % 2), 3'h1 << c, 3'h0, 1'h1);
        rd(NWDS_OFF_CAN_CFG, 32'h1);
        lp_try(1'h0, 3'h7, 3'h7, 1'h0);
        bus(1'h1, NWDS_OFF_IRQ_EN, 32'h2);
        irq_is(1'h1);
        bus(1'h1, NWDS_OFF_IRQ_EN, 32'h0);
        irq_is(1'h0);
        bus(1'h1, NWDS_OFF_IRQ_EN, 32'h2);
        bus(1'h1, NWDS_OFF_IRQ_CLR, 32'h2);
        irq_is(1'h0);
        nap(3'h7, 4'h0, 1'h0, 32'h0);
        nap(3'h4, 4'hF, 1'h1, 32'h0);
        rd(NWDS_OFF_STATUS, 32'h10);
        bus(1'h1, NWDS_OFF_WK_EN, 32'hFFFF_FFFF);
        // Inputs 1 and 20 are not present on every variant, so only input 19 may show as a wake.
        nap(3'h7, 4'h0, 1'h0, 32'h0018_0002);
        rd(NWDS_OFF_IRQ_ST, 32'hD);
        repeat (2) @(posedge clk_i);
        chk("notes left", exp_q.size() + exp_w.size(), 32'h0);
        tally_and_finish();
    end
endmodule
